/* logic/dio_debounce.sv */
/*
 debounce filter for the totalizer input.
 assumes a synchronised input; disabled filter passes input straight.
*/
`timescale 1ns/1ps
module dio_debounce #(
    parameter int unsigned CW = 20
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // control
    input wire logic en_in,
    input wire logic [CW-1:0] stable_cyc_in,
    // data
    input wire logic d_in,
    output logic q_out
);
    logic [CW-1:0] cnt_r;

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cnt_r <= '0;
            q_out <= 1'b1;
        end else if (!en_in || d_in == q_out) begin
            cnt_r <= '0;
            q_out <= d_in;
        end else if (cnt_r + CW'(1) >= stable_cyc_in) begin
            cnt_r <= '0;
            q_out <= d_in;
        end else begin
            cnt_r <= cnt_r + CW'(1);
        end
    end

    property p_deb_stable;
        @(posedge clk_in) disable iff (sys_rst_in)
        (en_in && $past(en_in) && $changed(q_out))
            |-> ($past(cnt_r) + CW'(1) >= $past(stable_cyc_in));
    endproperty
    a_deb_stable: assert property (p_deb_stable)
        else $error("filtered input changed before stable time");
endmodule : dio_debounce

/* logic/dio_pkg.sv */
/*
 digital i/o, relay and totalizer block: shared constants and carriers.
 assumes one 125 mhz clock and a simple strobe register port.
*/
package dio_pkg;
    localparam int unsigned NLINE = 20;
    localparam int unsigned NRELAY = 8;
    localparam int unsigned NALARM = 2;
    localparam int unsigned AW = 8;
    localparam int unsigned DW = 32;
    localparam int unsigned DEB_W = 20;
    localparam int unsigned RELAY_LSB = 24;
    // register offsets (byte addresses)
    localparam logic [7:0] ADDR_LINE_DIR = 8'h00;
    localparam logic [7:0] ADDR_LINE_OUT = 8'h04;
    localparam logic [7:0] ADDR_RELAY = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_TOT_CTRL = 8'h10;
    localparam logic [7:0] ADDR_TOT_PRESET = 8'h14;
    localparam logic [7:0] ADDR_TOT_COUNT = 8'h18;
    localparam logic [7:0] ADDR_DEB_CYC = 8'h1c;
    localparam logic [7:0] ADDR_ALARM_CFG = 8'h20;
    localparam logic [7:0] ADDR_DISP = 8'h24;
    // totalizer control fields
    localparam int unsigned CTRL_DOWN = 0;
    localparam int unsigned CTRL_DEB_EN = 1;
    localparam int unsigned CTRL_INIT = 2;
    // alarm routing fields, one 16-bit half per alarm
    localparam int unsigned ALM_STRIDE = 16;
    localparam int unsigned ALM_LINE_LSB = 0;
    localparam int unsigned ALM_LINE_EN = 5;
    localparam int unsigned ALM_RELAY_LSB = 6;
    localparam int unsigned ALM_RELAY_EN = 9;
    // reset values and count limit
    localparam logic [19:0] LINE_DIR_RST = 20'h00000;
    localparam logic [19:0] LINE_OUT_RST = 20'hfffff;
    localparam logic [31:0] COUNT_MAX = 32'hffffffff;
    // timing
    localparam longint unsigned CLK_HZ = 125_000_000;
    localparam longint unsigned DEB_TIME_US = 1000;
    localparam longint unsigned DEB_CYC = CLK_HZ / 1_000_000 * DEB_TIME_US;
    localparam longint unsigned DISP_TIME_MS = 1000;
    localparam longint unsigned DISP_CYC = CLK_HZ / 1000 * DISP_TIME_MS;

    typedef struct packed {
        logic [31:0] status;
        logic [31:0] count;
    } dio_scan_s;
endpackage : dio_pkg

/* logic/dio_sync.sv */
/*
 two-stage synchroniser for a vector of levels.
 assumes inputs change slowly compared with the clock.
*/
`timescale 1ns/1ps
module dio_sync #(
    parameter int unsigned W = 1
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // levels
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            meta_r <= '0;
            q_out <= '0;
        end else begin
            meta_r <= d_in;
            q_out <= meta_r;
        end
    end
endmodule : dio_sync

/* logic/dio_top.sv */
/*
 digital i/o block: 20 open-collector lines, 8 relays, 32-bit totalizer,
 register port, scan record capture and a once-a-second display copy.
 assumes pins are asynchronous inputs and an external pull-up on each line.
*/
//
// Contract
// - twenty lines, each input or open-collector output
// - undriven line reads high through pull-up
// - output low wins over external high
// - line status is 20-bit word, lsb line zero
// - eight relays reported in status bits 24-31
// - totalizer is unsigned 32-bit count
// - counting only while external enable asserted
// - count up from zero or down from preset
// - totalizer never gated by scans or access
// - wrap past limit gives brief overflow flag
// - contact counts once when it opens
// - selectable debounce stops bounce counts
// - voltage input counts rising edges only
// - rated 5000/s plain, 500/s debounced
// - count reinitialised on reset or command
// - scan record holds line status and count
// - display copy of status refreshed each second
// - alarm can force a line low or relay closed
`timescale 1ns/1ps
module dio_top #(
    parameter int unsigned DEB_CYC = 32'(dio_pkg::DEB_CYC),
    parameter int unsigned DISP_CYC = 32'(dio_pkg::DISP_CYC)
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // register port
    input wire logic [dio_pkg::AW-1:0] addr_in,
    input wire logic [dio_pkg::DW-1:0] wr_data_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    output logic [dio_pkg::DW-1:0] rd_data_out,
    // field lines, open collector
    input wire logic [dio_pkg::NLINE-1:0] line_in,
    output logic [dio_pkg::NLINE-1:0] line_out,
    output logic [dio_pkg::NLINE-1:0] line_oe_out,
    // relays, 1 = closed
    output logic [dio_pkg::NRELAY-1:0] relay_out,
    // totalizer pins
    input wire logic tot_in,
    input wire logic tot_en_in,
    output logic count_overflow_flag_out,
    // alarms from the channel evaluator
    input wire logic [dio_pkg::NALARM-1:0] alarm_in,
    // scan interface
    input wire logic scan_req_in,
    output dio_pkg::dio_scan_s scan_rec_out,
    output logic scan_valid_out
);
    localparam int unsigned NL = dio_pkg::NLINE;
    localparam int unsigned NR = dio_pkg::NRELAY;

    logic [NL-1:0] line_dir_r;
    logic [NL-1:0] line_val_r;
    logic [NR-1:0] relay_r;
    logic [31:0] ctrl_r;
    logic [31:0] preset_r;
    logic [dio_pkg::DEB_W-1:0] deb_cyc_r;
    logic [31:0] alarm_cfg_r;
    logic [NL-1:0] drive_low_nxt;
    logic [NR-1:0] relay_nxt;
    logic [NL-1:0] line_sync;
    logic [1:0] tot_sync;
    logic tot_filt;
    logic tot_prev_r;
    logic [31:0] count_r;
    logic [31:0] count_nxt;
    logic ovf_nxt;
    logic [NL-1:0] line_stat_r;
    logic [31:0] status;
    logic [31:0] disp_r;
    logic [31:0] disp_cnt_r;
    logic disp_tick;
    logic init_cmd;
    logic count_evt;

    // pin synchronisers
    dio_sync #(.W(NL)) u_line_sync (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .d_in(line_in),
        .q_out(line_sync)
    );

    dio_sync #(.W(2)) u_tot_sync (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .d_in({tot_en_in, tot_in}),
        .q_out(tot_sync)
    );

    dio_debounce #(.CW(dio_pkg::DEB_W)) u_deb (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .en_in(ctrl_r[dio_pkg::CTRL_DEB_EN]),
        .stable_cyc_in(deb_cyc_r),
        .d_in(tot_sync[0]),
        .q_out(tot_filt)
    );

    assign init_cmd = wr_en_in && addr_in == dio_pkg::ADDR_TOT_CTRL
        && wr_data_in[dio_pkg::CTRL_INIT];
    // contact opening and voltage low-to-high are both a rising edge;
    // one-clock edge detect leaves wide margin over the rated event rate
    assign count_evt = tot_sync[1] && tot_filt
        && !tot_prev_r;
    assign status = {relay_r, 4'h0, line_stat_r};
    assign disp_tick = disp_cnt_r == 32'(DISP_CYC - 1);

    // software-written configuration
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            line_dir_r <= dio_pkg::LINE_DIR_RST;
            line_val_r <= dio_pkg::LINE_OUT_RST;
            relay_r <= '0;
            ctrl_r <= '0;
            preset_r <= '0;
            deb_cyc_r <= DEB_CYC[dio_pkg::DEB_W-1:0];
            alarm_cfg_r <= '0;
        end else if (wr_en_in) begin
            unique case (addr_in)
                dio_pkg::ADDR_LINE_DIR: begin
                    line_dir_r <= wr_data_in[NL-1:0];
                end
                dio_pkg::ADDR_LINE_OUT: line_val_r <= wr_data_in[NL-1:0];
                dio_pkg::ADDR_RELAY: relay_r <= wr_data_in[NR-1:0];
                dio_pkg::ADDR_TOT_CTRL: begin
                    // init is a command, not stored
                    ctrl_r <= wr_data_in & ~(32'h1 << dio_pkg::CTRL_INIT);
                end
                dio_pkg::ADDR_TOT_PRESET: preset_r <= wr_data_in;
                dio_pkg::ADDR_DEB_CYC: begin
                    deb_cyc_r <= wr_data_in[dio_pkg::DEB_W-1:0];
                end
                dio_pkg::ADDR_ALARM_CFG: alarm_cfg_r <= wr_data_in;
                default: ;
            endcase
        end
    end

    // alarm routing onto lines and relays
    always_comb begin
        drive_low_nxt = line_dir_r & ~line_val_r;
        relay_nxt = relay_r;
        for (int a = 0; a < dio_pkg::NALARM; a++) begin
            if (alarm_in[a]) begin
                if (alarm_cfg_r[a*dio_pkg::ALM_STRIDE
                        + dio_pkg::ALM_LINE_EN]) begin
                    drive_low_nxt[alarm_cfg_r[a*dio_pkg::ALM_STRIDE
                        + dio_pkg::ALM_LINE_LSB +: 5]] = 1'b1;
                end
                if (alarm_cfg_r[a*dio_pkg::ALM_STRIDE
                        + dio_pkg::ALM_RELAY_EN]) begin
                    relay_nxt[alarm_cfg_r[a*dio_pkg::ALM_STRIDE
                        + dio_pkg::ALM_RELAY_LSB +: 3]] = 1'b1;
                end
            end
        end
    end

    // pin drive; a line select above 19 is simply ignored
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            line_out <= '0;
            line_oe_out <= '0;
            relay_out <= '0;
        end else begin
            line_out <= '0;
            line_oe_out <= drive_low_nxt;
            relay_out <= relay_nxt;
        end
    end

    // line read-back: own low drive dominates the pulled-up pin
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            line_stat_r <= '0;
        end else begin
            line_stat_r <= line_sync & ~line_oe_out;
        end
    end

    // totalizer next value
    always_comb begin
        count_nxt = count_r;
        ovf_nxt = 1'b0;
        if (init_cmd) begin
            count_nxt = wr_data_in[dio_pkg::CTRL_DOWN]
                ? preset_r : '0;
        end else if (count_evt) begin
            if (ctrl_r[dio_pkg::CTRL_DOWN]) begin
                count_nxt = count_r - 32'h1;
                ovf_nxt = count_r == 32'h0;
            end else begin
                count_nxt = count_r + 32'h1;
                ovf_nxt = count_r == dio_pkg::COUNT_MAX;
            end
        end
    end

    // runs every cycle, never gated by scan or bus traffic
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            count_r <= '0;
            tot_prev_r <= 1'b1;
            count_overflow_flag_out <= 1'b0;
        end else begin
            count_r <= count_nxt;
            tot_prev_r <= tot_filt;
            count_overflow_flag_out <= ovf_nxt;
        end
    end

    // display copy
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            disp_cnt_r <= '0;
            disp_r <= '0;
        end else begin
            disp_cnt_r <= disp_tick ? '0 : disp_cnt_r + 32'h1;
            if (disp_tick) begin
                disp_r <= status;
            end
        end
    end

    // scan record capture
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            scan_rec_out <= '0;
            scan_valid_out <= 1'b0;
        end else begin
            scan_valid_out <= scan_req_in;
            if (scan_req_in) begin
                scan_rec_out.status <= status;
                scan_rec_out.count <= count_r;
            end
        end
    end

    // register read, one cycle later; unmapped reads zero
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rd_data_out <= '0;
        end else if (rd_en_in) begin
            unique case (addr_in)
                dio_pkg::ADDR_LINE_DIR: rd_data_out <= 32'(line_dir_r);
                dio_pkg::ADDR_LINE_OUT: rd_data_out <= 32'(line_val_r);
                dio_pkg::ADDR_RELAY: rd_data_out <= 32'(relay_r);
                dio_pkg::ADDR_STATUS: rd_data_out <= status;
                dio_pkg::ADDR_TOT_CTRL: rd_data_out <= ctrl_r;
                dio_pkg::ADDR_TOT_PRESET: rd_data_out <= preset_r;
                dio_pkg::ADDR_TOT_COUNT: rd_data_out <= count_r;
                dio_pkg::ADDR_DEB_CYC: rd_data_out <= 32'(deb_cyc_r);
                dio_pkg::ADDR_ALARM_CFG: rd_data_out <= alarm_cfg_r;
                dio_pkg::ADDR_DISP: rd_data_out <= disp_r;
                default: rd_data_out <= '0;
            endcase
        end else begin
            rd_data_out <= '0;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    property p_low_wins;
        (line_stat_r & $past(line_oe_out)) == '0;
    endproperty
    a_low_wins: assert property (p_low_wins)
        else $error("driven-low line read high");

    property p_pullup;
        ##1 (line_stat_r == ($past(line_sync) & ~$past(line_oe_out)));
    endproperty
    a_pullup: assert property (p_pullup)
        else $error("line status not pin level under own drive");

    property p_relay_bits;
        (rd_en_in && addr_in == dio_pkg::ADDR_STATUS)
            |=> rd_data_out[31:24] == $past(relay_r)
                && rd_data_out[19:0] == $past(line_stat_r);
    endproperty
    a_relay_bits: assert property (p_relay_bits)
        else $error("status word layout wrong");

    property p_hold_disabled;
        (!tot_sync[1] && !init_cmd) |=> $stable(count_r);
    endproperty
    a_hold_disabled: assert property (p_hold_disabled)
        else $error("count moved while disabled");

    property p_init;
        init_cmd |=> count_r == ($past(wr_data_in[dio_pkg::CTRL_DOWN])
            ? $past(preset_r) : 32'h0);
    endproperty
    a_init: assert property (p_init)
        else $error("initialise command did not load count");

    property p_step;
        (count_evt && !init_cmd) |=> count_r == ($past(ctrl_r[0])
            ? $past(count_r) - 32'h1 : $past(count_r) + 32'h1);
    endproperty
    a_step: assert property (p_step)
        else $error("count step wrong");

    property p_wrap;
        (count_evt && !init_cmd && !ctrl_r[0]
            && count_r == dio_pkg::COUNT_MAX)
            |=> count_overflow_flag_out && count_r == 32'h0
                ##1 !count_overflow_flag_out;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("overflow not flagged on wrap");

    property p_disp;
        $changed(disp_r) |-> $past(disp_tick);
    endproperty
    a_disp: assert property (p_disp)
        else $error("display copy changed off the second tick");

    property p_scan;
        scan_req_in |=> scan_valid_out
            && scan_rec_out.count == $past(count_r)
            && scan_rec_out.status == $past(status);
    endproperty
    a_scan: assert property (p_scan)
        else $error("scan record not captured");

    c_wrap: cover property (count_overflow_flag_out);
    c_scan: cover property (scan_req_in ##1 scan_valid_out);
    c_alarm: cover property (|alarm_in ##1 |line_oe_out);
    c_down: cover property (count_evt && ctrl_r[0]);
endmodule : dio_top

/* tb/dio_field_model.sv */
/*
 field side model: pulled-up line wires, external lows, totalizer source.
 assumes the bench calls its tasks; every change lands on a rising edge.
*/
`timescale 1ns/1ps
module dio_field_model (
    // clock
    input wire logic clk_in,
    // device side of the lines
    input wire logic [19:0] line_oe_in,
    input wire logic [19:0] line_drv_in,
    // wire levels and totalizer pins
    output logic [19:0] line_lvl_out,
    output logic tot_out,
    output logic tot_en_out
);
    logic [19:0] ext_low_r = 20'h00000;

    initial begin
        tot_out = 1'b0;
        tot_en_out = 1'b0;
    end

    // pull-up wins only where nobody pulls low
    assign line_lvl_out = ~(ext_low_r | (line_oe_in & ~line_drv_in));

    task automatic set_ext(input logic [19:0] v);
        @(posedge clk_in);
        ext_low_r <= v;
    endtask : set_ext

    task automatic set_en(input logic v);
        @(posedge clk_in);
        tot_en_out <= v;
        repeat (4) @(posedge clk_in);
    endtask : set_en

    task automatic lvl(input logic v, input int n);
        @(posedge clk_in);
        tot_out <= v;
        repeat (n - 1) @(posedge clk_in);
    endtask : lvl

    // 12-cycle holds stand for the rated rate, scaled with the filter
    task automatic pulses(input int n, input logic bounce);
        for (int i = 0; i < n; i++) begin
            if (bounce) begin
                lvl(1'b1, 2);
                lvl(1'b0, 2);
            end
            lvl(1'b1, 12);
            if (bounce) begin
                lvl(1'b0, 2);
                lvl(1'b1, 2);
            end
            lvl(1'b0, 12);
        end
    endtask : pulses
endmodule : dio_field_model

/* tb/tb_top.sv */
/*
 self-checking bench for the digital i/o block.
 assumes small debounce and display counts; field model owns the pins.
*/
`timescale 1ns/1ps
module tb_top;
    logic clk_in;
    logic sys_rst_in;
    logic [dio_pkg::AW-1:0] addr_in;
    logic [dio_pkg::DW-1:0] wr_data_in;
    logic wr_en_in;
    logic rd_en_in;
    logic [dio_pkg::DW-1:0] rd_data_out;
    logic [19:0] line_lvl;
    logic [19:0] line_drv;
    logic [19:0] line_oe;
    logic [7:0] relay_out;
    logic tot_in;
    logic tot_en_in;
    logic ovf;
    logic [1:0] alarm_in;
    logic scan_req_in;
    logic scan_valid_out;
    dio_pkg::dio_scan_s scan_rec_out;
    int mismatches = 0;
    int checks_done = 0;
    int ovf_seen = 0;
    logic [31:0] rv;

    dio_top #(.DEB_CYC(4), .DISP_CYC(16)) dut (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
        .wr_data_in(wr_data_in), .wr_en_in(wr_en_in),
        .rd_en_in(rd_en_in), .rd_data_out(rd_data_out),
        .line_in(line_lvl), .line_out(line_drv), .line_oe_out(line_oe),
        .relay_out(relay_out), .tot_in(tot_in), .tot_en_in(tot_en_in),
        .count_overflow_flag_out(ovf), .alarm_in(alarm_in),
        .scan_req_in(scan_req_in), .scan_rec_out(scan_rec_out),
        .scan_valid_out(scan_valid_out));

    dio_field_model fm (
        .clk_in(clk_in), .line_oe_in(line_oe), .line_drv_in(line_drv),
        .line_lvl_out(line_lvl), .tot_out(tot_in), .tot_en_out(tot_en_in));

    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end

    always @(posedge clk_in) begin
        if (ovf === 1'b1) ovf_seen++;
    end

    task automatic chk(input logic [31:0] got, exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wr_data_in <= d;
        wr_en_in <= 1'b1;
        @(posedge clk_in);
        wr_en_in <= 1'b0;
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                       input string msg);
        @(posedge clk_in);
        addr_in <= a;
        rd_en_in <= 1'b1;
        @(posedge clk_in);
        rd_en_in <= 1'b0;
        #1 rv = rd_data_out;
        chk(rv, e, msg);
    endtask : rdc

    task automatic t_reset_vals;
        chk({12'h000, line_oe}, 32'h0, "oe after reset");
        rdc(dio_pkg::ADDR_LINE_DIR, 32'h0, "dir reset");
        rdc(dio_pkg::ADDR_LINE_OUT, 32'h000fffff, "out reset");
        rdc(dio_pkg::ADDR_RELAY, 32'h0, "relay reset");
        rdc(dio_pkg::ADDR_TOT_CTRL, 32'h0, "ctrl reset");
        rdc(dio_pkg::ADDR_TOT_PRESET, 32'h0, "preset reset");
        rdc(dio_pkg::ADDR_TOT_COUNT, 32'h0, "count reset");
        rdc(dio_pkg::ADDR_DEB_CYC, 32'h4, "deb reset");
        rdc(dio_pkg::ADDR_ALARM_CFG, 32'h0, "alarm reset");
        rdc(8'h3c, 32'h0, "unmapped read");
        wr(dio_pkg::ADDR_STATUS, 32'hffffffff);
        rdc(dio_pkg::ADDR_STATUS, 32'h000fffff, "idle status");
    endtask : t_reset_vals

    task automatic t_lines;
        fm.set_ext(20'h00020);
        wr(dio_pkg::ADDR_LINE_DIR, 32'h00080001);
        wr(dio_pkg::ADDR_LINE_OUT, 32'h0007fffe);
        tick(4);
        chk({12'h000, line_oe}, 32'h00080001, "oe lines");
        rdc(dio_pkg::ADDR_STATUS, 32'h0007ffde, "driven status");
        fm.set_ext(20'h00000);
        wr(dio_pkg::ADDR_LINE_DIR, 32'h0);
        tick(4);
        rdc(dio_pkg::ADDR_STATUS, 32'h000fffff, "released");
    endtask : t_lines

    task automatic t_relay;
        wr(dio_pkg::ADDR_RELAY, 32'ha5);
        tick(2);
        chk({24'h0, relay_out}, 32'ha5, "relay pins");
        rdc(dio_pkg::ADDR_STATUS, 32'ha50fffff, "relay status");
        wr(dio_pkg::ADDR_RELAY, 32'h0);
    endtask : t_relay

    task automatic t_count_up;
        wr(dio_pkg::ADDR_TOT_CTRL, 32'h4);
        fm.pulses(2, 1'b0);
        rdc(dio_pkg::ADDR_TOT_COUNT, 32'h0, "enable low");
        fm.set_en(1'b1);
        fm.pulses(3, 1'b0);
        rdc(dio_pkg::ADDR_TOT_COUNT, 32'h3, "rising only");
        fm.pulses(1, 1'b1);
        rdc(dio_pkg::ADDR_TOT_COUNT, 32'h6, "raw bounce");
    endtask : t_count_up

    task automatic t_scan;
        fork
            fm.pulses(4, 1'b0);
            begin
                tick(5);
                wr(dio_pkg::ADDR_RELAY, 32'h81);
                rdc(dio_pkg::ADDR_RELAY, 32'h81, "busy access");
            end
        join
        @(posedge clk_in);
        scan_req_in <= 1'b1;
        @(posedge clk_in);
        scan_req_in <= 1'b0;
        #1 chk({31'h0, scan_valid_out}, 32'h1, "scan valid");
        chk(scan_rec_out.count, 32'ha, "scan count");
        chk(scan_rec_out.status, 32'h810fffff, "scan status");
        wr(dio_pkg::ADDR_RELAY, 32'h0);
    endtask : t_scan

    task automatic t_down_wrap;
        wr(dio_pkg::ADDR_TOT_PRESET, 32'h2);
        wr(dio_pkg::ADDR_TOT_CTRL, 32'h5);
        rdc(dio_pkg::ADDR_TOT_COUNT, 32'h2, "preset load");
        ovf_seen = 0;
        fm.pulses(2, 1'b0);
        rdc(dio_pkg::ADDR_TOT_COUNT, 32'h0, "down to zero");
        chk(ovf_seen, 0, "no early flag");
        fm.pulses(1, 1'b0);
        rdc(dio_pkg::ADDR_TOT_COUNT, 32'hffffffff, "wrap");
        chk(ovf_seen, 1, "one flag");
        fm.pulses(1, 1'b0);
        rdc(dio_pkg::ADDR_TOT_COUNT, 32'hfffffffe, "after wrap");
        wr(dio_pkg::ADDR_TOT_PRESET, 32'hffffffff);
        wr(dio_pkg::ADDR_TOT_CTRL, 32'h5);
        wr(dio_pkg::ADDR_TOT_CTRL, 32'h0);
        fm.pulses(1, 1'b0);
        rdc(dio_pkg::ADDR_TOT_COUNT, 32'h0, "up wrap");
        chk(ovf_seen, 2, "up wrap flag");
    endtask : t_down_wrap

    task automatic t_debounce;
        wr(dio_pkg::ADDR_TOT_CTRL, 32'h6);
        rdc(dio_pkg::ADDR_TOT_COUNT, 32'h0, "init cmd");
        fm.pulses(2, 1'b1);
        rdc(dio_pkg::ADDR_TOT_COUNT, 32'h2, "bounce filtered");
        wr(dio_pkg::ADDR_DEB_CYC, 32'h3);
        rdc(dio_pkg::ADDR_DEB_CYC, 32'h3, "deb write");
    endtask : t_debounce

    task automatic t_alarm;
        wr(dio_pkg::ADDR_ALARM_CFG, 32'h03f902a3);
        rdc(dio_pkg::ADDR_ALARM_CFG, 32'h03f902a3, "alarm cfg");
        @(posedge clk_in);
        alarm_in <= 2'b01;
        tick(5);
        chk({12'h0, line_oe}, 32'h8, "alarm line");
        chk({24'h0, relay_out}, 32'h4, "alarm relay");
        alarm_in <= 2'b10;
        tick(5);
        chk({12'h0, line_oe}, 32'h0, "line select ignored");
        chk({24'h0, relay_out}, 32'h80, "alarm2 relay");
        alarm_in <= 2'b00;
        tick(5);
        rdc(dio_pkg::ADDR_RELAY, 32'h0, "relay reg kept");
    endtask : t_alarm

    task automatic t_disp;
        fm.set_ext(20'h0000f);
        tick(40);
        rdc(dio_pkg::ADDR_DISP, 32'h000ffff0, "display copy");
        fm.set_ext(20'h00000);
    endtask : t_disp

    task automatic t_reinit;
        fm.pulses(1, 1'b0);
        @(posedge clk_in);
        sys_rst_in <= 1'b1;
        tick(2);
        sys_rst_in <= 1'b0;
        rdc(dio_pkg::ADDR_TOT_COUNT, 32'h0, "count after reset");
        rdc(dio_pkg::ADDR_TOT_CTRL, 32'h0, "ctrl after reset");
    endtask : t_reinit

    task automatic report_and_stop;
        if (mismatches == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        #100000;
        mismatches++;
        report_and_stop();
    end

    initial begin
        sys_rst_in = 1'b1;
        addr_in <= 8'h00;
        wr_data_in <= 32'h0;
        wr_en_in <= 1'b0;
        rd_en_in <= 1'b0;
        alarm_in <= 2'b00;
        scan_req_in <= 1'b0;
        tick(10);
        sys_rst_in <= 1'b0;
        tick(4);
        t_reset_vals();
        t_lines();
        t_relay();
        t_count_up();
        t_scan();
        t_down_wrap();
        t_debounce();
        t_alarm();
        t_disp();
        t_reinit();
        report_and_stop();
    end
endmodule : tb_top
